/* als_cfg.svh */
// constants for the alert summary status block: offsets, bit positions, resets, bounds
`ifndef ALS_CFG_SVH
`define ALS_CFG_SVH

// ------------------------------------------------------------------
// widths
// ------------------------------------------------------------------
`define ALS_SUM_W 16
`define ALS_CELL_N 14
`define ALS_AUX_N 6
`define ALS_VAL_W 16
`define ALS_CAL_N 5
`define ALS_ADDR_W 8

// ------------------------------------------------------------------
// summary bit positions
// ------------------------------------------------------------------
`define ALS_B_CONV_CELL_OVER 15
`define ALS_B_CMP_CELL_OVER 14
`define ALS_B_CONV_CELL_UNDER 13
`define ALS_B_CMP_CELL_UNDER 12
`define ALS_B_CONV_AUX_COLD 11
`define ALS_B_CMP_AUX_COLD 10
`define ALS_B_CONV_AUX_HOT 9
`define ALS_B_CMP_AUX_HOT 8
`define ALS_B_CHARGE_HIGH 7
`define ALS_B_DISCHARGE_HIGH 6
`define ALS_B_UNUSED 5
`define ALS_B_CONV_OFS_CAL 4
`define ALS_B_RAMP_OFS_CAL 3
`define ALS_B_RATIO_OFS_CAL 2
`define ALS_B_PYR_GAIN_CAL 1
`define ALS_B_RAMP_GAIN_CAL 0

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define ALS_OFS_SUMMARY 8'h00
`define ALS_OFS_IRQ_STATUS 8'h04
`define ALS_OFS_IRQ_MASK 8'h08
`define ALS_OFS_CHG_THR 8'h0C
`define ALS_OFS_DIS_THR 8'h10
`define ALS_OFS_CAL0 8'h14
`define ALS_CAL_STRIDE 8'h04

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define ALS_RST_SUMMARY 16'h0000
`define ALS_RST_IRQ 16'h0000
`define ALS_RST_CHG_THR 16'hFFFF
`define ALS_RST_DIS_THR 16'h0000
`define ALS_RST_CAL 16'h0000

// ------------------------------------------------------------------
// calibration bounds, inclusive
// ------------------------------------------------------------------
`define ALS_CONV_OFS_MIN 16'h0000
`define ALS_CONV_OFS_MAX 16'h00FF
`define ALS_RAMP_OFS_MIN 16'h0000
`define ALS_RAMP_OFS_MAX 16'h00FF
`define ALS_RATIO_OFS_MIN 16'h0000
`define ALS_RATIO_OFS_MAX 16'h00FF
`define ALS_PYR_GAIN_MIN 16'h7000
`define ALS_PYR_GAIN_MAX 16'h9000
`define ALS_RAMP_GAIN_MIN 16'h7000
`define ALS_RAMP_GAIN_MAX 16'h9000

`endif

/* als_pkg.sv */
// types shared by the alert summary status block
package als_pkg;
`include "als_cfg.svh"

   typedef logic [`ALS_CELL_N-1:0] als_cell_t;
   typedef logic [`ALS_AUX_N-1:0] als_aux_t;
   typedef logic [`ALS_VAL_W-1:0] als_val_t;

   // one acquisition's evaluated per-channel alert vectors
   typedef struct packed {
      logic acq_done;
      als_cell_t cell_over_vec;
      als_cell_t cmp_cell_over_vec;
      als_cell_t cell_under_vec;
      als_cell_t cmp_cell_under_vec;
      als_aux_t aux_cold_vec;
      als_aux_t cmp_aux_cold_vec;
      als_aux_t aux_hot_vec;
      als_aux_t cmp_aux_hot_vec;
   } als_volt_s;

   typedef struct packed {
      logic done;
      als_val_t value;
   } als_csa_s;

   typedef enum logic [2:0] {
      CAL_CONV_OFS,
      CAL_RAMP_OFS,
      CAL_RATIO_OFS,
      CAL_PYR_GAIN,
      CAL_RAMP_GAIN
   } als_cal_kind_e;

   typedef struct packed {
      logic done;
      als_cal_kind_e kind;
      als_val_t value;
   } als_cal_s;
endpackage

/* als_alert_summary.sv */
// alert summary status register with avalon-mm slave and interrupt
//
// Contract
// - bit 15: OR of converter cell overvoltage
// - bit 13: OR of converter cell undervoltage
// - bit 11: OR of converter aux cold
// - bit 10: OR of comparator aux cold
// - bit 9: OR of converter aux hot
// - bit 8: OR of comparator aux hot
// - voltage summaries clear at resolved acquisition only
// - bit 7: current above charge threshold
// - bit 6: current below discharge threshold
// - current flags clear at resolved measurement only
// - bit 4: converter offset calibration fault
// - bit 3: ramp shift-amp offset calibration fault
// - bit 2: ratiometric offset calibration fault
// - bit 1: pyramid gain calibration fault
// - bit 0: ramp gain calibration fault
// - cal fault clears on in-bounds run/write
`timescale 1ns/1ps
`include "als_cfg.svh"

module als_alert_summary (
   input wire logic mclk, // 40 MHz clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [`ALS_ADDR_W-1:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire als_pkg::als_volt_s volt_in, // per-channel voltage alerts
   input wire als_pkg::als_cell_t cell_alert_en, // per-cell alert enables
   input wire als_pkg::als_aux_t aux_alert_en, // per-aux alert enables
   input wire als_pkg::als_csa_s csa_in, // current-sense result
   input wire als_pkg::als_cal_s cal_in, // calibration run result
   output logic [`ALS_SUM_W-1:0] alert_summary, // summary register
   output logic irq // level interrupt
);
   import als_pkg::*;

   // ------------------------------------------------------------------
   // functions
   // ------------------------------------------------------------------
   function automatic logic cal_in_bounds(input als_cal_kind_e kind, input als_val_t v);
      logic ok;
      ok = 1'b0;
      unique case (kind)
         CAL_CONV_OFS: begin
            ok = (v >= `ALS_CONV_OFS_MIN) && (v <= `ALS_CONV_OFS_MAX);
         end
         CAL_RAMP_OFS: begin
            ok = (v >= `ALS_RAMP_OFS_MIN) && (v <= `ALS_RAMP_OFS_MAX);
         end
         CAL_RATIO_OFS: begin
            ok = (v >= `ALS_RATIO_OFS_MIN) && (v <= `ALS_RATIO_OFS_MAX);
         end
         CAL_PYR_GAIN: begin
            ok = (v >= `ALS_PYR_GAIN_MIN) && (v <= `ALS_PYR_GAIN_MAX);
         end
         CAL_RAMP_GAIN: begin
            ok = (v >= `ALS_RAMP_GAIN_MIN) && (v <= `ALS_RAMP_GAIN_MAX);
         end
         // an unused kind code never counts as in bounds
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [`ALS_SUM_W-1:0] summary_reg;
   logic [`ALS_SUM_W-1:0] summary_next;
   logic [`ALS_SUM_W-1:0] irq_status_reg;
   logic [`ALS_SUM_W-1:0] irq_status_next;
   logic [`ALS_SUM_W-1:0] irq_mask_reg;
   logic [`ALS_SUM_W-1:0] irq_mask_next;
   als_val_t chg_thr_reg;
   als_val_t chg_thr_next;
   als_val_t dis_thr_reg;
   als_val_t dis_thr_next;
   als_val_t cal_value_reg [0:`ALS_CAL_N-1];
   als_val_t cal_value_next [0:`ALS_CAL_N-1];
   logic wait_reg;
   logic wait_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic irq_reg;
   logic irq_next;

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   // one wait cycle: the request is seen while wait_reg is high, answered the next cycle
   wire bus_req = avs_read | avs_write;
   wire bus_accept = bus_req & wait_reg;
   wire wr_fire = avs_write & ~wait_reg;
   wire wr_status = wr_fire && (avs_address == `ALS_OFS_IRQ_STATUS);
   wire wr_mask = wr_fire && (avs_address == `ALS_OFS_IRQ_MASK);
   wire wr_chg = wr_fire && (avs_address == `ALS_OFS_CHG_THR);
   wire wr_dis = wr_fire && (avs_address == `ALS_OFS_DIS_THR);
   wire als_val_t wdata16 = avs_writedata[`ALS_VAL_W-1:0];

   assign wait_next = ~bus_accept;
   assign irq_mask_next = wr_mask ? wdata16 : irq_mask_reg;
   assign chg_thr_next = wr_chg ? wdata16 : chg_thr_reg;
   assign dis_thr_next = wr_dis ? wdata16 : dis_thr_reg;

   // ------------------------------------------------------------------
   // voltage summaries
   // ------------------------------------------------------------------
   als_cell_t cell_v [0:3];
   als_aux_t aux_v [0:3];
   logic [7:0] vsum_now;
   logic [7:0] vsum_next;

   assign cell_v[0] = volt_in.cell_over_vec;
   assign cell_v[1] = volt_in.cmp_cell_over_vec;
   assign cell_v[2] = volt_in.cell_under_vec;
   assign cell_v[3] = volt_in.cmp_cell_under_vec;
   assign aux_v[0] = volt_in.aux_cold_vec;
   assign aux_v[1] = volt_in.cmp_aux_cold_vec;
   assign aux_v[2] = volt_in.aux_hot_vec;
   assign aux_v[3] = volt_in.cmp_aux_hot_vec;

   for (genvar j = 0; j < 4; j++) begin : g_vsum
      // only enabled channels take part
      assign vsum_now[7-j] = |(cell_v[j] & cell_alert_en);
      assign vsum_now[3-j] = |(aux_v[j] & aux_alert_en);
   end

   // a bit is dropped only by an acquisition that finds every enabled channel clear
   assign vsum_next = vsum_now | (summary_reg[15:8] & {8{~volt_in.acq_done}});

   // ------------------------------------------------------------------
   // current-sense flags
   // ------------------------------------------------------------------
   wire chg_next = csa_in.done ? (csa_in.value > chg_thr_reg) :
      summary_reg[`ALS_B_CHARGE_HIGH];
   wire dis_next = csa_in.done ? (csa_in.value < dis_thr_reg) :
      summary_reg[`ALS_B_DISCHARGE_HIGH];

   // ------------------------------------------------------------------
   // calibration faults and values
   // ------------------------------------------------------------------
   logic [`ALS_CAL_N-1:0] cal_fault_next;
   logic [`ALS_CAL_N-1:0] cal_run_hit;
   logic [`ALS_CAL_N-1:0] cal_wr_hit;
   logic [`ALS_CAL_N-1:0] cal_rd_hit;
   als_val_t cal_rd_chain [0:`ALS_CAL_N];

   assign cal_rd_chain[0] = '0;

   for (genvar i = 0; i < `ALS_CAL_N; i++) begin : g_cal
      wire [`ALS_ADDR_W-1:0] cal_addr = `ALS_OFS_CAL0 + 8'(i) * `ALS_CAL_STRIDE;
      wire als_cal_kind_e kind = als_cal_kind_e'(i);
      wire fault_now = summary_reg[`ALS_B_CONV_OFS_CAL-i];
      assign cal_run_hit[i] = cal_in.done && (cal_in.kind == kind);
      assign cal_wr_hit[i] = wr_fire && (avs_address == cal_addr);
      assign cal_rd_hit[i] = avs_address == cal_addr;
      // a run overrides a host write landing in the same cycle
      assign cal_value_next[i] = cal_run_hit[i] ? cal_in.value :
         cal_wr_hit[i] ? wdata16 : cal_value_reg[i];
      assign cal_fault_next[`ALS_B_CONV_OFS_CAL-i] = cal_run_hit[i] ?
         ~cal_in_bounds(kind, cal_in.value) :
         (cal_wr_hit[i] && cal_in_bounds(kind, wdata16)) ? 1'b0 : fault_now;
      assign cal_rd_chain[i+1] = cal_rd_chain[i] | (cal_rd_hit[i] ? cal_value_reg[i] : '0);
   end

   // ------------------------------------------------------------------
   // summary assembly and interrupt
   // ------------------------------------------------------------------
   // only an in-bounds calibration write reaches the summary, clearing its fault bit; the spare bit is tied low
   assign summary_next = {vsum_next, chg_next, dis_next, 1'b0, cal_fault_next};

   // set wins over a write-one clear in the same cycle
   wire [`ALS_SUM_W-1:0] rise = summary_next & ~summary_reg;
   wire [`ALS_SUM_W-1:0] w1c = wr_status ? wdata16 : '0;
   assign irq_status_next = rise | (irq_status_reg & ~w1c);
   assign irq_next = |(irq_status_next & irq_mask_next);

   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------
   wire als_val_t rd_mux = (avs_address == `ALS_OFS_SUMMARY) ? summary_reg :
      (avs_address == `ALS_OFS_IRQ_STATUS) ? irq_status_reg :
      (avs_address == `ALS_OFS_IRQ_MASK) ? irq_mask_reg :
      (avs_address == `ALS_OFS_CHG_THR) ? chg_thr_reg :
      (avs_address == `ALS_OFS_DIS_THR) ? dis_thr_reg :
      cal_rd_chain[`ALS_CAL_N];
   assign rdata_next = (bus_accept && avs_read) ? {16'h0000, rd_mux} : rdata_reg;

   // ------------------------------------------------------------------
   // flip-flops
   // ------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         summary_reg <= `ALS_RST_SUMMARY;
         irq_status_reg <= `ALS_RST_IRQ;
         irq_mask_reg <= `ALS_RST_IRQ;
         chg_thr_reg <= `ALS_RST_CHG_THR;
         dis_thr_reg <= `ALS_RST_DIS_THR;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
         irq_reg <= 1'b0;
      end else begin
         summary_reg <= summary_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         chg_thr_reg <= chg_thr_next;
         dis_thr_reg <= dis_thr_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   for (genvar i = 0; i < `ALS_CAL_N; i++) begin : g_cal_ff
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            cal_value_reg[i] <= `ALS_RST_CAL;
         end else begin
            cal_value_reg[i] <= cal_value_next[i];
         end
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign alert_summary = summary_reg;
   assign irq = irq_reg;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   conv_cell_over_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      |(volt_in.cell_over_vec & cell_alert_en) |=> summary_reg[`ALS_B_CONV_CELL_OVER])
      else $error("converter cell overvoltage summary not set");

   cmp_cell_over_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      |(volt_in.cmp_cell_over_vec & cell_alert_en) |=> summary_reg[`ALS_B_CMP_CELL_OVER])
      else $error("comparator cell overvoltage summary not set");

   conv_cell_under_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      |(volt_in.cell_under_vec & cell_alert_en) |=> summary_reg[`ALS_B_CONV_CELL_UNDER])
      else $error("converter cell undervoltage summary not set");

   cmp_cell_under_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      |(volt_in.cmp_cell_under_vec & cell_alert_en) |=> summary_reg[`ALS_B_CMP_CELL_UNDER])
      else $error("comparator cell undervoltage summary not set");

   conv_aux_cold_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      |(volt_in.aux_cold_vec & aux_alert_en) |=> summary_reg[`ALS_B_CONV_AUX_COLD])
      else $error("converter aux cold summary not set");

   cmp_aux_cold_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      |(volt_in.cmp_aux_cold_vec & aux_alert_en) |=> summary_reg[`ALS_B_CMP_AUX_COLD])
      else $error("comparator aux cold summary not set");

   conv_aux_hot_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      |(volt_in.aux_hot_vec & aux_alert_en) |=> summary_reg[`ALS_B_CONV_AUX_HOT])
      else $error("converter aux hot summary not set");

   cmp_aux_hot_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      |(volt_in.cmp_aux_hot_vec & aux_alert_en) |=> summary_reg[`ALS_B_CMP_AUX_HOT])
      else $error("comparator aux hot summary not set");

   volt_hold_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !volt_in.acq_done |=> ((summary_reg[15:8] & $past(summary_reg[15:8]))
         == $past(summary_reg[15:8])))
      else $error("voltage summary dropped between acquisitions");

   volt_clear_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      volt_in.acq_done && !(|(volt_in.cell_over_vec & cell_alert_en))
         |=> !summary_reg[`ALS_B_CONV_CELL_OVER])
      else $error("resolved acquisition did not clear summary");

   aux_hot_clear_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      volt_in.acq_done && !(|(volt_in.cmp_aux_hot_vec & aux_alert_en))
         |=> !summary_reg[`ALS_B_CMP_AUX_HOT])
      else $error("resolved acquisition did not clear comparator aux hot summary");

   charge_flag_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      csa_in.done |=> summary_reg[`ALS_B_CHARGE_HIGH]
         == ($past(csa_in.value) > $past(chg_thr_reg)))
      else $error("charge current flag wrong after measurement");

   discharge_flag_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      csa_in.done |=> summary_reg[`ALS_B_DISCHARGE_HIGH]
         == ($past(csa_in.value) < $past(dis_thr_reg)))
      else $error("discharge current flag wrong after measurement");

   csa_hold_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !csa_in.done |=> $stable(summary_reg[7:6]))
      else $error("current flags changed without a measurement");

   cal_run_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      cal_in.done && (cal_in.kind == CAL_CONV_OFS) |=> summary_reg[`ALS_B_CONV_OFS_CAL]
         == !cal_in_bounds(CAL_CONV_OFS, $past(cal_in.value)))
      else $error("offset calibration fault wrong after run");

   ramp_ofs_run_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      cal_in.done && (cal_in.kind == CAL_RAMP_OFS) |=> summary_reg[`ALS_B_RAMP_OFS_CAL]
         == (($past(cal_in.value) < `ALS_RAMP_OFS_MIN) ||
         ($past(cal_in.value) > `ALS_RAMP_OFS_MAX)))
      else $error("ramp offset calibration fault wrong after run");

   ratio_ofs_run_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      cal_in.done && (cal_in.kind == CAL_RATIO_OFS) |=> summary_reg[`ALS_B_RATIO_OFS_CAL]
         == (($past(cal_in.value) < `ALS_RATIO_OFS_MIN) ||
         ($past(cal_in.value) > `ALS_RATIO_OFS_MAX)))
      else $error("ratiometric offset calibration fault wrong after run");

   pyr_gain_run_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      cal_in.done && (cal_in.kind == CAL_PYR_GAIN) |=> summary_reg[`ALS_B_PYR_GAIN_CAL]
         == (($past(cal_in.value) < `ALS_PYR_GAIN_MIN) ||
         ($past(cal_in.value) > `ALS_PYR_GAIN_MAX)))
      else $error("pyramid gain calibration fault wrong after run");

   ramp_gain_run_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      cal_in.done && (cal_in.kind == CAL_RAMP_GAIN) |=> summary_reg[`ALS_B_RAMP_GAIN_CAL]
         == (($past(cal_in.value) < `ALS_RAMP_GAIN_MIN) ||
         ($past(cal_in.value) > `ALS_RAMP_GAIN_MAX)))
      else $error("ramp gain calibration fault wrong after run");

   cal_write_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      cal_wr_hit[4] && !cal_run_hit[4] && cal_in_bounds(CAL_RAMP_GAIN, wdata16)
         |=> !summary_reg[`ALS_B_RAMP_GAIN_CAL])
      else $error("in-bounds write did not clear ramp gain fault");

   cal_write_keep_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      cal_wr_hit[0] && !cal_run_hit[0] && (wdata16 > `ALS_CONV_OFS_MAX)
         |=> summary_reg[`ALS_B_CONV_OFS_CAL] == $past(summary_reg[`ALS_B_CONV_OFS_CAL]))
      else $error("out-of-bounds write changed offset calibration fault");

   spare_bit_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !summary_reg[`ALS_B_UNUSED])
      else $error("spare summary bit set");

   bus_answer_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");

   irq_level_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ##1 irq == |($past(irq_status_next) & $past(irq_mask_next)))
      else $error("interrupt does not follow masked status");

   status_set_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $rose(summary_reg[`ALS_B_CONV_CELL_OVER]) |-> irq_status_reg[`ALS_B_CONV_CELL_OVER])
      else $error("rising summary bit did not set its status bit");
endmodule

/* tb_top.sv */
// self-checking bench for the alert summary status block
`timescale 1ns/1ps
`include "als_cfg.svh"

module tb_top;
   import als_pkg::*;
   logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
   logic [`ALS_ADDR_W-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [`ALS_SUM_W-1:0] alert_summary, exp_sum;
   als_volt_s volt_in;
   als_cell_t cell_alert_en;
   als_aux_t aux_alert_en;
   als_csa_s csa_in;
   als_cal_s cal_in;
   als_val_t lo_b [5];
   als_val_t hi_b [5];
   int errors = 0;
   int total_checks = 0;

   als_alert_summary dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .volt_in(volt_in),
      .cell_alert_en(cell_alert_en), .aux_alert_en(aux_alert_en), .csa_in(csa_in),
      .cal_in(cal_in), .alert_summary(alert_summary), .irq(irq));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic summarize;
      $display("errors %0d checks %0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask

   // the request stands until the rising edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (i < 20) begin
         rd = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
      end else begin
         errors++;
         summarize();
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("readdata at %h", a), e, rd);
   endtask

   task automatic sum_chk(input logic [15:0] e);
      @(negedge mclk);
      chk("alert_summary", {16'h0000, e}, {16'h0000, alert_summary});
   endtask

   task automatic volt(input int k, input logic [13:0] v, input logic done);
      als_volt_s s;
      @(posedge mclk);
      s = volt_in;
      s.acq_done = done;
      case (k)
         0: s.cell_over_vec = v;
         1: s.cmp_cell_over_vec = v;
         2: s.cell_under_vec = v;
         3: s.cmp_cell_under_vec = v;
         4: s.aux_cold_vec = v[5:0];
         5: s.cmp_aux_cold_vec = v[5:0];
         6: s.aux_hot_vec = v[5:0];
         default: s.cmp_aux_hot_vec = v[5:0];
      endcase
      volt_in <= s;
      @(posedge mclk);
      volt_in.acq_done <= 1'b0;
   endtask

   task automatic current_sense_amp(input logic [15:0] v);
      @(posedge mclk);
      csa_in <= '{done: 1'b1, value: v};
      @(posedge mclk);
      csa_in.done <= 1'b0;
   endtask

   task automatic cal(input int k, input logic [15:0] v);
      @(posedge mclk);
      cal_in <= '{done: 1'b1, kind: als_cal_kind_e'(k), value: v};
      @(posedge mclk);
      cal_in.done <= 1'b0;
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      summarize();
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      logic [13:0] top;
      rst_n = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      volt_in = '0;
      cell_alert_en = '1;
      aux_alert_en = '1;
      csa_in = '0;
      cal_in = '0;
      exp_sum = 16'h0000;
      lo_b = '{`ALS_CONV_OFS_MIN, `ALS_RAMP_OFS_MIN, `ALS_RATIO_OFS_MIN, `ALS_PYR_GAIN_MIN,
               `ALS_RAMP_GAIN_MIN};
      hi_b = '{`ALS_CONV_OFS_MAX, `ALS_RAMP_OFS_MAX, `ALS_RATIO_OFS_MAX, `ALS_PYR_GAIN_MAX,
               `ALS_RAMP_GAIN_MAX};
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      sum_chk(16'h0000);
      for (int i = 0; i < 10; i++) begin
         rdchk(8'(4 * i), (i == 3) ? 32'h0000FFFF : 32'h0);
      end
      // voltage summaries: set on any enabled bit, clear only at a resolved acquisition
      cell_alert_en[5] <= 1'b0;
      volt(0, 14'h0020, 1'b0);
      sum_chk(16'h0000);
      volt(0, 14'h0000, 1'b1);
      cell_alert_en[5] <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         top = (k < 4) ? 14'h2000 : 14'h0020;
         volt(k, top, 1'b0);
         exp_sum[15 - k] = 1'b1;
         sum_chk(exp_sum);
         volt(k, 14'h0000, 1'b0);
         sum_chk(exp_sum);
         volt(k, 14'h0001, 1'b1);
         sum_chk(exp_sum);
         volt(k, 14'h0000, 1'b1);
         exp_sum[15 - k] = 1'b0;
         sum_chk(exp_sum);
      end
      // current-sense flags at the threshold boundaries
      bus(1'b1, `ALS_OFS_CHG_THR, 32'h00001000);
      bus(1'b1, `ALS_OFS_DIS_THR, 32'h00000100);
      rdchk(`ALS_OFS_CHG_THR, 32'h00001000);
      current_sense_amp(16'h1001);
      sum_chk(16'h0080);
      current_sense_amp(16'h1000);
      sum_chk(16'h0000);
      current_sense_amp(16'h00FF);
      sum_chk(16'h0040);
      @(posedge mclk);
      csa_in.value <= 16'h5000;
      sum_chk(16'h0040);
      current_sense_amp(16'h0100);
      sum_chk(16'h0000);
      // calibration faults, one kind at a time
      for (int k = 0; k < 5; k++) begin
         cal(k, hi_b[k] + 16'h0001);
         sum_chk(16'h0001 << (4 - k));
         rdchk(`ALS_OFS_CAL0 + 8'(4 * k), {16'h0000, hi_b[k] + 16'h0001});
         bus(1'b1, `ALS_OFS_CAL0 + 8'(4 * k), {16'h0000, hi_b[k] + 16'h0002});
         sum_chk(16'h0001 << (4 - k));
         bus(1'b1, `ALS_OFS_CAL0 + 8'(4 * k), {16'h0000, hi_b[k]});
         sum_chk(16'h0000);
         cal(k, lo_b[k] - 16'h0001);
         sum_chk(16'h0001 << (4 - k));
         cal(k, lo_b[k]);
         sum_chk(16'h0000);
      end
      cal(5, 16'hFFFF);
      sum_chk(16'h0000);
      // interrupt, read-only summary and unmapped places
      bus(1'b1, `ALS_OFS_IRQ_STATUS, 32'h0000FFFF);
      bus(1'b1, `ALS_OFS_IRQ_MASK, 32'h00008000);
      rdchk(`ALS_OFS_IRQ_STATUS, 32'h0);
      volt(0, 14'h0001, 1'b0);
      @(negedge mclk);
      chk("irq", 32'h1, irq);
      rdchk(`ALS_OFS_IRQ_STATUS, 32'h00008000);
      bus(1'b1, `ALS_OFS_SUMMARY, 32'h0000FFFF);
      rdchk(`ALS_OFS_SUMMARY, 32'h00008000);
      bus(1'b1, `ALS_OFS_IRQ_STATUS, 32'h00008000);
      @(negedge mclk);
      chk("irq", 32'h0, irq);
      volt(2, 14'h0001, 1'b0);
      @(negedge mclk);
      chk("irq", 32'h0, irq);
      rdchk(`ALS_OFS_IRQ_STATUS, 32'h00002000);
      bus(1'b1, 8'h40, 32'h0000FFFF);
      rdchk(8'h40, 32'h0);
      rdchk(8'h02, 32'h0);
      rdchk(`ALS_OFS_IRQ_MASK, 32'h00008000);
      volt(0, 14'h0000, 1'b0);
      volt(2, 14'h0000, 1'b1);
      sum_chk(16'h0000);
      summarize();
   end
endmodule
